// ===== rtl/switch_monitor_core.sv
/*
 * Command and status core of a 22-input switch monitor with a serial
 * slave port. Assumes the master keeps the serial clock low around chip
 * select edges, leaves four system clocks between chip select fall and
 * the first rising serial edge, and that comparator results arrive as
 * levels that are high when the input is above the threshold.
 */
`default_nettype none

module switch_monitor_core
	import switch_monitor_pkg::*;
#(
	parameter logic [7:0] OP_RESET = OP_RESET_DEF
) (
	input wire logic clk_i, // System clock, 25 MHz.
	input wire logic reset_i, // Power-on reset from battery supply.
	input wire logic sclk_i, // Serial clock from the master.
	input wire logic cs_n_i, // Chip select, active low.
	input wire logic si_i, // Serial data in.
	output logic so_o, // Serial data out.
	output logic so_oe_o, // Serial out driver enable.
	input wire logic int_n_i, // Interrupt pin level.
	output logic int_n_o, // Interrupt pin drive value.
	output logic int_n_oe_o, // Interrupt pin pull-down enable.
	input wire logic wake_n_i, // Wake pin level.
	output logic wake_n_o, // Wake pin drive value.
	output logic wake_n_oe_o, // Wake pin pull-down enable.
	input wire logic logic_supply_i, // Logic supply present.
	input wire logic thermal_flag_i, // Over-temperature comparator.
	input wire logic [PROG_W-1:0] programmable_inputs_i, // Above threshold.
	input wire logic [GND_W-1:0] ground_only_inputs_i, // Above threshold.
	input wire logic sleep_req_i, // Sleep request pulse.
	input wire logic int_timer_expired_i, // Interrupt timer pulse.
	output logic normal_mode_o, // Device in Normal Mode.
	output logic temp_monitor_en_o, // Temperature monitor enable.
	output logic [PROG_W-1:0] input_polarity_select_o, // 1 battery sense.
	output logic [SW_W-1:0] wake_interrupt_enable_o, // Per-input enable.
	output logic [SW_W-1:0] wetting_level_select_o, // 1 high current.
	output logic [SW_W-1:0] wetting_timer_enable_o, // Timer enables.
	output logic [SW_W-1:0] tristate_select_o, // Input tri-state.
	output logic [ASEL_W-1:0] analog_select_o // Analog channel.
);

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		logic [SYNC_W-1:0] s3;
		logic [SYNC_W-1:0] filt;
		mode_type mode;
		logic [PROG_W-1:0] polarity;
		logic [SW_W-1:0] wake_en;
		logic [SW_W-1:0] wetting;
		logic [SW_W-1:0] timer_en;
		logic [SW_W-1:0] tristate;
		logic [ASEL_W-1:0] analog;
		logic [SW_W-1:0] prev_closed;
		logic int_act;
		logic chg_in_frame;
		logic [WORD_W-1:0] snap;
	} sys_state_type;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [WORD_W-1:0] shift;
	} link_state_type;

	sys_state_type q;
	sys_state_type next_q;
	link_state_type lq;
	link_state_type next_lq;
	logic start;
	logic so_bit;
	logic so_oe;

	// ----------------------------------------------------------------
	// System domain next-state logic
	// ----------------------------------------------------------------
	// Chip select, wake, interrupt, supply, thermal and switch pins pass three
	// flops; a bit moves only when flops two and three agree, which suppresses
	// a single sample of metastability.
	always_comb begin
		logic [SYNC_W-1:0] nf;
		logic [SW_W-1:0] closed;
		logic [SW_W-1:0] en_chg;
		logic cs_fall;
		logic cs_rise;
		logic wake_fall;
		logic int_fall;
		logic vdd;
		logic normal;
		logic set_int;
		logic wake_evt;
		logic [7:0] op;
		nf = '0;
		closed = '0;
		en_chg = '0;
		cs_fall = 1'b0;
		cs_rise = 1'b0;
		wake_fall = 1'b0;
		int_fall = 1'b0;
		vdd = 1'b0;
		normal = 1'b0;
		set_int = 1'b0;
		wake_evt = 1'b0;
		op = 8'h00;
		next_q = q;
		next_q.s1 = {cs_n_i, wake_n_i, int_n_i, logic_supply_i,
			thermal_flag_i, programmable_inputs_i, ground_only_inputs_i};
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		nf = (q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3));
		next_q.filt = nf;
		cs_fall = q.filt[SY_CS] & ~nf[SY_CS];
		cs_rise = ~q.filt[SY_CS] & nf[SY_CS];
		wake_fall = q.filt[SY_WAKE] & ~nf[SY_WAKE];
		int_fall = q.filt[SY_INT] & ~nf[SY_INT];
		vdd = nf[SY_VDD];
		normal = (q.mode == MODE_NORMAL);
		op = lq.shift[OP_MSB:OP_LSB];
		// Polarity picks the closed sense; closed always reads as one.
		closed[SW_W-1:GND_W] = ~(q.polarity ^
			nf[SY_PROG_LSB+:PROG_W]);
		closed[GND_W-1:0] = ~nf[SY_GND_LSB+:GND_W];
		next_q.prev_closed = closed;
		en_chg = (closed ^ q.prev_closed) & q.wake_en;

		// Mode: supply loss is deliberately absent from both arms.
		wake_evt = (|en_chg) | wake_fall | int_timer_expired_i |
			(int_fall & vdd & nf[SY_WAKE]) |
			(cs_fall & vdd);
		unique case (q.mode)
			MODE_SLEEP: begin
				if (wake_evt) begin
					next_q.mode = MODE_NORMAL;
				end
			end
			MODE_NORMAL: begin
				if (sleep_req_i && !wake_evt) begin
					next_q.mode = MODE_SLEEP;
				end
			end
			default: begin
				next_q.mode = MODE_NORMAL;
			end
		endcase

		// Interrupt: a new change in the clearing cycle keeps it set.
		set_int = normal & (|en_chg);
		if (cs_fall) begin
			next_q.chg_in_frame = set_int;
		end else if (set_int && !nf[SY_CS]) begin
			next_q.chg_in_frame = 1'b1;
		end
		if (set_int) begin
			next_q.int_act = 1'b1;
		end else if (cs_rise && !q.chg_in_frame) begin
			next_q.int_act = 1'b0;
		end

		// Snapshot of the status word taken at chip select fall.
		if (cs_fall) begin
			next_q.snap[ST_INT] = q.int_act;
			next_q.snap[ST_THERM] = nf[SY_THERM] & normal;
			next_q.snap[ST_PROG_LSB+:PROG_W] = closed[SW_W-1:GND_W];
			next_q.snap[GND_W-1:0] = closed[GND_W-1:0];
		end

		// Commands act only at the frame end with a full 24-bit word.
		if (cs_rise && vdd && normal &&
			lq.cnt == FRAME_BITS) begin
			if (op == OP_POLARITY) begin
				next_q.polarity = lq.shift[PROG_W-1:0];
			end else if (op == OP_WAKE_PROG) begin
				next_q.wake_en[SW_W-1:GND_W] =
					lq.shift[PROG_W-1:0];
			end else if (op == OP_WAKE_GND) begin
				next_q.wake_en[GND_W-1:0] =
					lq.shift[GND_W-1:0];
			end else if (op == OP_WET_PROG) begin
				next_q.wetting[SW_W-1:GND_W] =
					lq.shift[PROG_W-1:0];
			end else if (op == OP_WET_GND) begin
				next_q.wetting[GND_W-1:0] =
					lq.shift[GND_W-1:0];
			end else if (op == OP_RESET) begin
				next_q.polarity = POLARITY_RST;
				next_q.wake_en = WAKE_EN_RST;
				next_q.wetting = WETTING_RST;
				next_q.timer_en = TIMER_EN_RST;
				next_q.tristate = TRISTATE_RST;
				next_q.analog = ANALOG_RST;
			end
			// Any other opcode falls through unchanged.
		end
	end

	// ----------------------------------------------------------------
	// System domain register
	// ----------------------------------------------------------------
	// Reset stands for battery application and lands in Normal Mode.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
			q.s1 <= SYNC_IDLE;
			q.s2 <= SYNC_IDLE;
			q.s3 <= SYNC_IDLE;
			q.filt <= SYNC_IDLE;
			q.mode <= MODE_NORMAL;
			q.polarity <= POLARITY_RST;
			q.wake_en <= WAKE_EN_RST;
			q.wetting <= WETTING_RST;
			q.timer_en <= TIMER_EN_RST;
			q.tristate <= TRISTATE_RST;
			q.analog <= ANALOG_RST;
		end else begin
			q <= next_q;
		end
	end

	// ----------------------------------------------------------------
	// Serial output enable
	// ----------------------------------------------------------------
	// Release is immediate at chip select rise; enable follows the
	// filtered low level, so there is no output without logic supply.
	always_ff @(posedge clk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			so_oe <= 1'b0;
		end else if (reset_i) begin
			so_oe <= 1'b0;
		end else begin
			so_oe <= ~q.filt[SY_CS] & q.filt[SY_VDD];
		end
	end

	// ----------------------------------------------------------------
	// Link domain: frame start marker
	// ----------------------------------------------------------------
	// The serial clock stops between frames, so chip select high marks
	// the next falling edge as the first of a frame.
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			start <= 1'b1;
		end else begin
			start <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Link domain: input shift and bit count
	// ----------------------------------------------------------------
	// One register shifts the snapshot out and the command in, so after
	// 24 bits it forwards what it received to a chained device.
	always_comb begin
		next_lq = lq;
		if (start) begin
			next_lq.cnt = 6'h01;
			next_lq.shift = {q.snap[WORD_W-2:0], si_i};
		end else begin
			if (lq.cnt != CNT_MAX) begin
				next_lq.cnt = lq.cnt + 6'h01;
			end
			next_lq.shift = {lq.shift[WORD_W-2:0], si_i};
		end
	end

	always_ff @(negedge sclk_i) begin
		lq <= next_lq;
	end

	// ----------------------------------------------------------------
	// Link domain: serial output bit
	// ----------------------------------------------------------------
	// The first rising edge shows the status MSB; the snapshot is stable
	// by then because it was taken a few system clocks after the fall.
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			so_bit <= 1'b0;
		end else if (start) begin
			so_bit <= q.snap[WORD_W-1];
		end else begin
			so_bit <= lq.shift[WORD_W-1];
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Both open-drain pins only ever pull low.
	assign so_o = so_bit;
	assign so_oe_o = so_oe;
	assign int_n_o = 1'b0;
	assign int_n_oe_o = q.int_act;
	assign wake_n_o = 1'b0;
	assign wake_n_oe_o = q.mode[0];
	assign normal_mode_o = q.mode[0];
	assign temp_monitor_en_o = q.mode[0];
	assign input_polarity_select_o = q.polarity;
	assign wake_interrupt_enable_o = q.wake_en;
	assign wetting_level_select_o = q.wetting;
	assign wetting_timer_enable_o = q.timer_en;
	assign tristate_select_o = q.tristate;
	assign analog_select_o = q.analog;

endmodule : switch_monitor_core

`default_nettype wire

// ===== rtl/switch_monitor_pkg.sv
/*
 * Constants, command codes, defaults and status layout of the switch
 * monitor command core. Assumes one 24-bit serial word per frame.
 */
`default_nettype none

package switch_monitor_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int PROG_W = 8;
	localparam int GND_W = 14;
	localparam int SW_W = 22;
	localparam int WORD_W = 24;
	localparam int CNT_W = 6;
	localparam int SYNC_W = 27;
	localparam int ASEL_W = 5;

	// ----------------------------------------------------------------
	// Frame, opcodes and defaults
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] FRAME_BITS = 6'h18;
	localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
	localparam int OP_MSB = 23;
	localparam int OP_LSB = 16;
	localparam logic [7:0] OP_POLARITY = 8'h01;
	localparam logic [7:0] OP_WAKE_PROG = 8'h02;
	localparam logic [7:0] OP_WAKE_GND = 8'h03;
	localparam logic [7:0] OP_WET_PROG = 8'h04;
	localparam logic [7:0] OP_WET_GND = 8'h05;
	localparam logic [7:0] OP_RESET_DEF = 8'h0C;
	localparam logic [PROG_W-1:0] POLARITY_RST = 8'hFF;
	localparam logic [SW_W-1:0] WAKE_EN_RST = 22'h3FFFFF;
	localparam logic [SW_W-1:0] WETTING_RST = 22'h3FFFFF;
	localparam logic [SW_W-1:0] TIMER_EN_RST = 22'h3FFFFF;
	localparam logic [SW_W-1:0] TRISTATE_RST = 22'h3FFFFF;
	localparam logic [ASEL_W-1:0] ANALOG_RST = 5'h00;

	// ----------------------------------------------------------------
	// Status word and synchroniser bit positions
	// ----------------------------------------------------------------
	localparam int ST_INT = 23;
	localparam int ST_THERM = 22;
	localparam int ST_PROG_LSB = 14;
	localparam int SY_GND_LSB = 0;
	localparam int SY_PROG_LSB = 14;
	localparam int SY_THERM = 22;
	localparam int SY_VDD = 23;
	localparam int SY_INT = 24;
	localparam int SY_WAKE = 25;
	localparam int SY_CS = 26;
	// Idle pins: selects and supply high, ground-only inputs open, so
	// the first compare after reset sees no false switch change.
	localparam logic [SYNC_W-1:0] SYNC_IDLE = 27'h7803FFF;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b01,
		MODE_SLEEP = 2'b10
	} mode_type;

endpackage : switch_monitor_pkg

`default_nettype wire

// ===== testbench/spi_master_model.sv
/*
 * Serial master model: runs one frame of any bit count on its own clock.
 * Assumes the device drives serial out only while its enable is high.
 */
`default_nettype none

module spi_master_model (
	output logic sclk_o, // Serial clock, low outside frames.
	output logic cs_n_o, // Chip select, active low.
	output logic si_o, // Data to the device.
	input wire logic so_i, // Device serial out.
	input wire logic so_oe_i // Device serial out enable.
);
	timeunit 1ns;
	timeprecision 100ps;
	logic last = 1'b0;
	wire logic line;

	// A released line shows the inverse of its last value, never a
	// stale copy that could pass for real data.
	assign line = so_oe_i ? so_i : ~last;

	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end

	// One frame, most significant bit first, 64 ns serial period. The
	// link logic keeps up at this rate; the rate cap guards the analog
	// side, so a real master runs slower.
	task automatic xfer(input logic [23:0] cmd, input int n,
		output logic [23:0] rx);
		int i;
		rx = 24'h000000;
		#7 cs_n_o = 1'b0;
		#250;
		for (i = n - 1; i >= 0; i--) begin
			si_o = cmd[i % 24];
			#16 sclk_o = 1'b1;
			#32 sclk_o = 1'b0;
			rx = {rx[22:0], line};
			last = line;
			#16;
		end
		cs_n_o = 1'b1;
		si_o = ~si_o;
		#300;
	endtask : xfer

endmodule : spi_master_model

`default_nettype wire

// ===== testbench/switch_monitor_core_sva.sv
/*
 * Checker for the switch monitor core: serial release, supply gating,
 * mode changes and configuration update timing.
 * Assumes it is bound to the core and sees only its ports.
 */
`default_nettype none

module switch_monitor_core_sva
	import switch_monitor_pkg::*;
(
	input wire logic clk_i, // System clock.
	input wire logic reset_i, // Synchronous reset.
	input wire logic cs_n_i, // Chip select.
	input wire logic so_oe_o, // Serial out enable.
	input wire logic logic_supply_i, // Logic supply present.
	input wire logic sleep_req_i, // Sleep request.
	input wire logic int_timer_expired_i, // Timer wake pulse.
	input wire logic normal_mode_o, // Normal Mode.
	input wire logic temp_monitor_en_o, // Temperature monitor.
	input wire logic [PROG_W-1:0] input_polarity_select_o, // Polarity.
	input wire logic [SW_W-1:0] wake_interrupt_enable_o, // Enables.
	input wire logic [SW_W-1:0] wetting_level_select_o // Wetting.
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// Shared timing
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// Chip select has stayed high over two samples.
	sequence s_idle;
		cs_n_i [*2];
	endsequence

	// The frame ended long enough ago for the command to cross over.
	sequence s_after_frame;
		cs_n_i && $past(cs_n_i, 3);
	endsequence

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	chk_so_released: assert property (s_idle |-> !so_oe_o)
		else $error("serial out driven while deselected");
	chk_no_supply_quiet: assert property (
		(!logic_supply_i) [*6] |-> !so_oe_o)
		else $error("serial out driven without logic supply");
	chk_temp_follows: assert property (
		temp_monitor_en_o == normal_mode_o)
		else $error("temperature monitor not tied to Normal Mode");
	chk_sleep_entry: assert property (
		sleep_req_i && !int_timer_expired_i |=> !normal_mode_o)
		else $error("sleep request ignored");
	chk_timer_wake: assert property (
		int_timer_expired_i |=> normal_mode_o)
		else $error("timer expiry did not wake");
	chk_cs_wake: assert property (
		$fell(cs_n_i) && logic_supply_i && !normal_mode_o
		|-> ##[1:8] normal_mode_o)
		else $error("chip select fall did not wake");
	chk_supply_mode: assert property (
		!logic_supply_i && normal_mode_o && !sleep_req_i
		|=> normal_mode_o)
		else $error("supply loss changed the mode");
	chk_cfg_timing: assert property (
		!$stable({input_polarity_select_o, wake_interrupt_enable_o,
		wetting_level_select_o}) |-> s_after_frame)
		else $error("configuration changed outside a frame end");
	chk_cfg_sleep_hold: assert property (
		!normal_mode_o |=> $stable({input_polarity_select_o,
		wake_interrupt_enable_o, wetting_level_select_o}))
		else $error("configuration changed in Sleep Mode");

endmodule : switch_monitor_core_sva

bind switch_monitor_core switch_monitor_core_sva i_switch_monitor_core_sva (
	.clk_i, .reset_i, .cs_n_i, .so_oe_o, .logic_supply_i, .sleep_req_i,
	.int_timer_expired_i, .normal_mode_o, .temp_monitor_en_o,
	.input_polarity_select_o, .wake_interrupt_enable_o,
	.wetting_level_select_o);

`default_nettype wire

// ===== testbench/switch_monitor_spi_command_core_tb.sv
/*
 * Self-checking bench for the switch monitor core: random and directed
 * frames, interrupt, mode, supply and reset scenarios.
 * Assumes the master model and checker are compiled before it.
 */
`default_nettype none

module switch_monitor_spi_command_core_tb
	import switch_monitor_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0, reset_i = 1'b1, sleep_req = 1'b0, tmr = 1'b0;
	logic supply = 1'b1, wake_pull = 1'b0, therm = 1'b0;
	logic [7:0] p_in = 8'h00, m_pol;
	logic [13:0] g_in = 14'h3FFF;
	logic [21:0] m_wake, m_wet;
	logic [23:0] rx, cmd;
	logic [22:0] st;
	wire logic sclk, cs_n, si, so, so_oe, int_oe, wake_oe, normal, temp;
	wire logic [7:0] pol;
	wire logic [21:0] wen, wet, tmr_en, tri_en;
	wire logic [4:0] asel;
	int error_cnt = 0, total_checks = 0, k, n;

	switch_monitor_core i_switch_monitor_core (.clk_i(clk_i),
		.reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
		.so_o(so), .so_oe_o(so_oe), .int_n_i(~int_oe), .int_n_o(),
		.int_n_oe_o(int_oe), .wake_n_i(~(wake_oe | wake_pull)),
		.wake_n_o(), .wake_n_oe_o(wake_oe), .logic_supply_i(supply),
		.thermal_flag_i(therm), .programmable_inputs_i(p_in),
		.ground_only_inputs_i(g_in), .sleep_req_i(sleep_req),
		.int_timer_expired_i(tmr), .normal_mode_o(normal),
		.temp_monitor_en_o(temp), .input_polarity_select_o(pol),
		.wake_interrupt_enable_o(wen), .wetting_level_select_o(wet),
		.wetting_timer_enable_o(tmr_en), .tristate_select_o(tri_en),
		.analog_select_o(asel));
	spi_master_model i_spi_master_model (.sclk_o(sclk), .cs_n_o(cs_n),
		.si_o(si), .so_i(so), .so_oe_i(so_oe));

	// The 25 MHz system clock.
	always #20 clk_i = ~clk_i;

	// Closed reads as one: polarity picks the sense, ground is inverted.
	function automatic logic [22:0] exp_st(logic [7:0] pl, logic [7:0] p,
		logic [13:0] g, logic th);
		return {th, pl ~^ p, ~g};
	endfunction : exp_st

	task automatic tick(input int c);
		repeat (c) @(posedge clk_i);
		#2;
	endtask : tick

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask : chk

	task automatic chk_regs();
		chk(24'(pol), 24'(m_pol));
		chk(24'(wen), 24'(m_wake));
		chk(24'(wet), 24'(m_wet));
	endtask : chk_regs

	// Reset and check every documented default but bit 2 of the analog select.
	task automatic por();
		reset_i = 1'b1;
		tick(12);
		reset_i = 1'b0;
		m_pol = 8'hFF;
		m_wake = 22'h3FFFFF;
		m_wet = 22'h3FFFFF;
		chk_regs();
		chk({tmr_en, asel[1:0]}, {22'h3FFFFF, 2'b00});
		chk({tri_en, asel[4:3]}, {22'h3FFFFF, 2'b00});
		chk(24'(normal), 24'h000001);
		chk(24'(temp), 24'h000001);
	endtask : por

	// One frame; the model follows only complete, accepted words.
	task automatic frame(input logic [23:0] c, input int nb, input logic a);
		i_spi_master_model.xfer(c, nb, rx);
		if (a && nb == 24) begin
			case (c[23:16])
				8'h01: m_pol = c[7:0];
				8'h02: m_wake[21:14] = c[7:0];
				8'h03: m_wake[13:0] = c[13:0];
				8'h04: m_wet[21:14] = c[7:0];
				8'h05: m_wet[13:0] = c[13:0];
				OP_RESET_DEF: begin
					m_pol = 8'hFF;
					m_wake = 22'h3FFFFF;
					m_wet = 22'h3FFFFF;
				end
				default: ;
			endcase
		end
		tick(8);
	endtask : frame

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask : pulse

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	// Watchdog: the sequence needs well under a third of this span.
	initial begin
		#3000000;
		error_cnt++;
		summarize();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hC95D));
		por();
		tick(6);
		chk(24'(int_oe), 24'h000000);
		for (k = 0; k < 30; k++) begin
			p_in = 8'($urandom);
			g_in = 14'($urandom);
			therm = 1'($urandom);
			tick(10);
			n = (k % 5 == 4) ? 23 + 2 * (k % 2) : 24;
			cmd = {8'($urandom_range(0, 13)), 16'($urandom)};
			st = exp_st(m_pol, p_in, g_in, therm);
			frame(cmd, n, 1'b1);
			if (n == 24) chk(24'(rx[22:0]), 24'(st));
			chk_regs();
		end
		frame(24'h5A3C96, 48, 1'b1);
		chk(rx, 24'h5A3C96);
		chk_regs();
		frame(24'h0200FF, 24, 1'b1);
		frame(24'h033FFF, 24, 1'b1);
		frame(24'h000000, 24, 1'b1);
		chk(24'(int_oe), 24'h000000);
		g_in[0] = ~g_in[0];
		tick(8);
		chk(24'(int_oe), 24'h000001);
		frame(24'h000000, 24, 1'b1);
		chk(24'(rx[23]), 24'h000001);
		chk(24'(int_oe), 24'h000000);
		fork
			frame(24'h000000, 24, 1'b1);
			begin
				tick(22);
				g_in[0] = ~g_in[0];
			end
		join
		chk(24'(int_oe), 24'h000001);
		frame(24'h030000, 24, 1'b1);
		g_in[0] = ~g_in[0];
		tick(8);
		chk(24'(int_oe), 24'h000000);
		supply = 1'b0;
		tick(6);
		chk(24'(normal), 24'h000001);
		pulse(sleep_req);
		frame(24'h010055, 24, 1'b0);
		chk(24'(normal), 24'h000000);
		chk(24'(temp), 24'h000000);
		chk(24'(wake_oe), 24'h000000);
		pulse(tmr);
		chk(24'(normal), 24'h000001);
		frame(24'h010055, 24, 1'b0);
		chk_regs();
		supply = 1'b1;
		tick(6);
		pulse(sleep_req);
		// Let the released wake line settle high, or the filter never
		// sees the level that the falling edge must start from.
		tick(6);
		chk(24'(normal), 24'h000000);
		wake_pull = 1'b1;
		tick(8);
		chk(24'(normal), 24'h000001);
		wake_pull = 1'b0;
		pulse(sleep_req);
		frame(24'h0100A5, 24, 1'b1);
		chk(24'(normal), 24'h000001);
		chk_regs();
		frame({OP_RESET_DEF, 16'h0000}, 24, 1'b1);
		chk_regs();
		por();
		summarize();
	end

endmodule : switch_monitor_spi_command_core_tb

`default_nettype wire
